// ==== logic/cbs_regs.svh ====
// register offsets, field positions, reset values and timing for the can bit segment block
`ifndef CBS_REGS_SVH
`define CBS_REGS_SVH
`define CBS_ADDR_W 4
`define CBS_OFF_PRESCALE 4'h6
`define CBS_OFF_BIT_SEGMENT 4'h7
`define CBS_OFF_DRIVER 4'h8
`define CBS_OFF_MODE_CTRL 4'h0
`define CBS_RST_PRESCALE 8'h00
`define CBS_RST_BIT_SEGMENT 8'h00
`define CBS_RST_DRIVER 8'h00
`define CBS_RST_MODE_CTRL 8'h01
`define CBS_MODE_CFG_BIT 0
`define CBS_MODE_SLEEP_BIT 1
`define CBS_SEG_SAMPLE_BIT 7
`define CBS_SEG_AFTER_MSB 6
`define CBS_SEG_AFTER_LSB 4
`define CBS_SEG_BEFORE_MSB 3
`define CBS_SEG_BEFORE_LSB 0
`define CBS_PRESCALE_MSB 5
`define CBS_PIN1_LSB 5
`define CBS_PIN0_LSB 2
`define CBS_OUT_MODE_MSB 1
`define CBS_SYNC_QUANTA 1
`endif

// ==== logic/cbs_pkg.sv ====
// types shared by the can bit segment and output driver block
package cbs_pkg;
   typedef enum logic [1:0] {
      CBS_MODE_BIPHASE = 2'h0,
      CBS_MODE_TEST = 2'h1,
      CBS_MODE_NORMAL = 2'h2,
      CBS_MODE_CLOCK = 2'h3
   } cbs_out_mode_e;
   // one pin's driver settings: high-side, low-side, polarity
   typedef struct packed {
      logic high_side;
      logic low_side;
      logic polarity;
   } cbs_drv_cfg_s;
   // one pin towards the pad: level and output enable
   typedef struct packed {
      logic level;
      logic oe;
   } cbs_pin_s;
   typedef struct packed {
      logic [7:0] rd_data;
      logic [3:0] addr;
      logic [7:0] wr_data;
      logic wr;
      logic rd;
   } cbs_bus_s;
endpackage : cbs_pkg

// ==== logic/cbs_pin_driver.sv ====
// one serial transmit pin driver: high and low side transistor choice
`timescale 1ns/1ps
`default_nettype none
module cbs_pin_driver (
   // settings and data
   input wire cbs_pkg::cbs_drv_cfg_s cfg,
   input wire logic tx_bit,
   input wire logic force_float,
   input wire logic force_recessive,
   // pad side
   output var cbs_pkg::cbs_pin_s pin
);
   import cbs_pkg::*;
   logic high_on;
   logic low_on;
   logic rec_high;
   logic rec_low;
   // low side when bit equals polarity, high side when it differs
   assign low_on = cfg.low_side & (tx_bit == cfg.polarity);
   assign high_on = cfg.high_side & (tx_bit != cfg.polarity);
   // recessive is what the pin shows for a one bit
   assign rec_low = cfg.low_side & cfg.polarity;
   assign rec_high = cfg.high_side & ~cfg.polarity;
   always_comb begin
      if (force_float) begin
         pin = '{level: 1'b0, oe: 1'b0};
      end else if (force_recessive) begin
         pin = '{level: rec_high, oe: rec_high | rec_low};
      end else begin
         pin = '{level: high_on, oe: high_on | low_on};
      end
   end
endmodule : cbs_pin_driver
`default_nettype wire

// ==== logic/cbs_quantum_timer.sv ====
// quantum prescaler: one-cycle enable every quantum period
`timescale 1ns/1ps
`default_nettype none
`include "cbs_regs.svh"
module cbs_quantum_timer (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // control
   input wire logic run,
   input wire logic [5:0] quantum_prescaler,
   // quantum tick
   output logic quantum_tick
);
   import cbs_pkg::*;
   typedef struct packed {
      logic [6:0] count;
      logic tick;
   } cbs_qt_state_s;
   cbs_qt_state_s state;
   cbs_qt_state_s next_state;
   logic [6:0] terminal;
   // twice the oscillator period times prescaler plus one
   assign terminal = {quantum_prescaler, 1'b1};
   always_comb begin
      next_state = state;
      next_state.tick = 1'b0;
      if (!run) begin
         next_state.count = 7'h00;
      end else if (state.count >= terminal) begin
         next_state.count = 7'h00;
         next_state.tick = 1'b1;
      end else begin
         next_state.count = state.count + 7'h01;
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
   assign quantum_tick = state.tick;
endmodule : cbs_quantum_timer
`default_nettype wire

// ==== logic/cbs_bit_timing.sv ====
// bit segment timing, sampling and serial transmit output driver control
`timescale 1ns/1ps
`default_nettype none
`include "cbs_regs.svh"
////////////////////////////////////////////////////////////////////////////////
module cbs_bit_timing (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rd_data,
   // transmit data from the protocol engine, same clock
   input wire logic tx_data,
   // receive comparator from the pad
   input wire logic rx_comp_pin,
   // sampled bus bit and its strobe
   output logic rx_bit,
   output logic rx_bit_valid,
   // bit start strobe towards the protocol engine
   output logic bit_start,
   // transmit pins: level and output enable
   output logic serial_tx_pin0,
   output logic serial_tx_pin0_oe,
   output logic serial_tx_pin1,
   output logic serial_tx_pin1_oe
);
   import cbs_pkg::*;
   typedef enum logic [1:0] {
      CBS_SYNC,
      CBS_BEFORE,
      CBS_AFTER
   } cbs_seg_e;
   typedef struct packed {
      logic [7:0] mode_ctrl;
      logic [7:0] prescale;
      logic [7:0] bit_segment_config;
      logic [7:0] driver_config;
      logic [7:0] rd_data;
      cbs_seg_e seg;
      logic [3:0] quanta;
      logic [2:0] samples;
      logic [1:0] sample_cnt;
      logic tx_bit;
      logic clk_pulse;
      logic biphase_pin1;
      logic rx_bit;
      logic rx_valid;
      logic bit_start;
      cbs_pin_s pin0;
      cbs_pin_s pin1;
      logic [1:0] rx_sync;
   } cbs_state_s;
   cbs_state_s state;
   cbs_state_s next_state;
   logic config_mode;
   logic sleep_mode;
   logic quantum_tick;
   logic rx_level;
   logic triple;
   logic [3:0] seg_before;
   logic [2:0] seg_after;
   cbs_out_mode_e out_mode;
   cbs_drv_cfg_s cfg0;
   cbs_drv_cfg_s cfg1;
   logic drv_bit0;
   logic drv_bit1;
   logic float0;
   logic float1;
   cbs_pin_s pin0_c;
   cbs_pin_s pin1_c;
   logic majority;
   ////////////////////////////////////////////////////////////////////////////////
   // field decode
   assign config_mode = state.mode_ctrl[`CBS_MODE_CFG_BIT];
   assign sleep_mode = state.mode_ctrl[`CBS_MODE_SLEEP_BIT];
   assign rx_level = state.rx_sync[1];
   assign triple = state.bit_segment_config[`CBS_SEG_SAMPLE_BIT];
   assign seg_before = state.bit_segment_config[`CBS_SEG_BEFORE_MSB:`CBS_SEG_BEFORE_LSB];
   assign seg_after = state.bit_segment_config[`CBS_SEG_AFTER_MSB:`CBS_SEG_AFTER_LSB];
   assign out_mode = cbs_out_mode_e'(state.driver_config[`CBS_OUT_MODE_MSB:0]);
   assign cfg1 = state.driver_config[`CBS_PIN1_LSB +: 3];
   assign cfg0 = state.driver_config[`CBS_PIN0_LSB +: 3];
   assign majority = (state.samples[0] & state.samples[1]) | (state.samples[0] & state.samples[2])
      | (state.samples[1] & state.samples[2]);
   ////////////////////////////////////////////////////////////////////////////////
   // quantum prescaler, halted in config mode so timing restarts cleanly
   cbs_quantum_timer u_quantum (
      .core_clk(core_clk),
      .resetn(resetn),
      .run(~config_mode),
      .quantum_prescaler(state.prescale[`CBS_PRESCALE_MSB:0]),
      .quantum_tick(quantum_tick)
   );
   ////////////////////////////////////////////////////////////////////////////////
   // per-mode bit routed to each pin driver
   always_comb begin
      drv_bit0 = state.tx_bit;
      drv_bit1 = state.tx_bit;
      float0 = 1'b0;
      float1 = 1'b0;
      case (out_mode)
         CBS_MODE_NORMAL: begin
            drv_bit1 = state.tx_bit;
         end
         CBS_MODE_CLOCK: begin
            drv_bit1 = state.clk_pulse;
         end
         CBS_MODE_TEST: begin
            drv_bit1 = rx_level;
         end
         CBS_MODE_BIPHASE: begin
            // dominant bit goes to one pin only, the other pin floats
            // so that the transformer sees no dc component
            drv_bit0 = state.tx_bit;
            drv_bit1 = state.tx_bit;
            float0 = state.tx_bit | state.biphase_pin1;
            float1 = state.tx_bit | ~state.biphase_pin1;
         end
         default: begin
            drv_bit1 = state.tx_bit;
         end
      endcase
   end
   cbs_pin_driver u_pin0 (
      .cfg(cfg0),
      .tx_bit(drv_bit0),
      .force_float(config_mode | float0),
      .force_recessive(sleep_mode),
      .pin(pin0_c)
   );
   cbs_pin_driver u_pin1 (
      .cfg(cfg1),
      .tx_bit(drv_bit1),
      .force_float(config_mode | float1),
      .force_recessive(sleep_mode),
      .pin(pin1_c)
   );
   ////////////////////////////////////////////////////////////////////////////////
   // register port, bit sequencer and sampling
   always_comb begin
      next_state = state;
      next_state.rx_sync = {state.rx_sync[0], rx_comp_pin};
      next_state.rx_valid = 1'b0;
      next_state.bit_start = 1'b0;
      next_state.rd_data = 8'h00;
      next_state.pin0 = pin0_c;
      next_state.pin1 = pin1_c;
      if (reg_wr) begin
         case (reg_addr)
            `CBS_OFF_MODE_CTRL: next_state.mode_ctrl = {6'h00, reg_wr_data[1:0]};
            `CBS_OFF_PRESCALE: if (config_mode) next_state.prescale = reg_wr_data;
            `CBS_OFF_BIT_SEGMENT: if (config_mode) next_state.bit_segment_config = reg_wr_data;
            `CBS_OFF_DRIVER: if (config_mode) next_state.driver_config = reg_wr_data;
            default: next_state.mode_ctrl = state.mode_ctrl;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            `CBS_OFF_MODE_CTRL: next_state.rd_data = state.mode_ctrl;
            `CBS_OFF_PRESCALE: next_state.rd_data = config_mode ? state.prescale : 8'h00;
            `CBS_OFF_BIT_SEGMENT: next_state.rd_data = config_mode ? state.bit_segment_config : 8'h00;
            `CBS_OFF_DRIVER: next_state.rd_data = config_mode ? state.driver_config : 8'h00;
            default: next_state.rd_data = 8'h00;
         endcase
      end
      if (config_mode) begin
         // hold the sequencer at a bit start while software reconfigures
         next_state.seg = CBS_SYNC;
         next_state.quanta = 4'h0;
         next_state.clk_pulse = 1'b0;
         next_state.biphase_pin1 = 1'b0;
         next_state.tx_bit = 1'b1;
      end else if (quantum_tick) begin
         next_state.clk_pulse = 1'b0;
         case (state.seg)
            CBS_SYNC: begin
               next_state.seg = CBS_BEFORE;
               next_state.quanta = 4'h0;
            end
            CBS_BEFORE: begin
               // last quanta of the first segment feed the triple sampler
               // widened so long segments do not wrap the comparison
               if ({1'b0, state.quanta} + 5'h02 >= {1'b0, seg_before}) begin
                  next_state.samples = {state.samples[1:0], rx_level};
               end
               if (state.quanta == seg_before) begin
                  next_state.seg = CBS_AFTER;
                  next_state.quanta = 4'h0;
                  next_state.rx_bit = triple ? majority : rx_level;
                  next_state.rx_valid = 1'b1;
               end else begin
                  next_state.quanta = state.quanta + 4'h1;
               end
            end
            CBS_AFTER: begin
               if (state.quanta == {1'b0, seg_after}) begin
                  next_state.seg = CBS_SYNC;
                  next_state.quanta = 4'h0;
                  next_state.bit_start = 1'b1;
                  next_state.tx_bit = tx_data;
                  next_state.clk_pulse = 1'b1;
                  if (state.tx_bit == 1'b0 && out_mode == CBS_MODE_BIPHASE) begin
                     next_state.biphase_pin1 = ~state.biphase_pin1;
                  end
               end else begin
                  next_state.quanta = state.quanta + 4'h1;
               end
            end
            default: begin
               next_state.seg = CBS_SYNC;
            end
         endcase
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state <= '0;
         state.mode_ctrl <= `CBS_RST_MODE_CTRL;
         state.prescale <= `CBS_RST_PRESCALE;
         state.bit_segment_config <= `CBS_RST_BIT_SEGMENT;
         state.driver_config <= `CBS_RST_DRIVER;
         state.seg <= CBS_SYNC;
         state.tx_bit <= 1'b1;
         state.rx_bit <= 1'b1;
      end else begin
         state <= next_state;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // outputs, all registered
   assign reg_rd_data = state.rd_data;
   assign rx_bit = state.rx_bit;
   assign rx_bit_valid = state.rx_valid;
   assign bit_start = state.bit_start;
   assign serial_tx_pin0 = state.pin0.level;
   assign serial_tx_pin0_oe = state.pin0.oe;
   assign serial_tx_pin1 = state.pin1.level;
   assign serial_tx_pin1_oe = state.pin1.oe;
   ////////////////////////////////////////////////////////////////////////////////
   // checks
   AST_CFG_FLOAT: assert property (@(posedge core_clk) disable iff (!resetn)
      $past(config_mode) && config_mode |-> !serial_tx_pin0_oe && !serial_tx_pin1_oe)
      else $error("transmit driver active in config mode");
   AST_WR_LOCK: assert property (@(posedge core_clk) disable iff (!resetn)
      reg_wr && reg_addr == `CBS_OFF_DRIVER && !config_mode |=> $stable(state.driver_config))
      else $error("driver register changed outside config mode");
   AST_RD_LOCK: assert property (@(posedge core_clk) disable iff (!resetn)
      reg_rd && reg_addr == `CBS_OFF_BIT_SEGMENT && !config_mode |=> reg_rd_data == 8'h00)
      else $error("segment register visible outside config mode");
   AST_SAMPLE_ONCE: assert property (@(posedge core_clk) disable iff (!resetn)
      quantum_tick && !config_mode && state.seg == CBS_BEFORE && state.quanta == seg_before
      && !triple |=> rx_bit == $past(rx_level))
      else $error("single sample mismatch");
   AST_AFTER_LEN: assert property (@(posedge core_clk) disable iff (!resetn)
      rx_bit_valid |-> state.seg == CBS_AFTER && state.quanta == 4'h0)
      else $error("sample point not at segment boundary");
   AST_BIT_START: assert property (@(posedge core_clk) disable iff (!resetn)
      bit_start |-> state.seg == CBS_SYNC && state.clk_pulse)
      else $error("bit start without sync segment");
   AST_SLEEP_REC: assert property (@(posedge core_clk) disable iff (!resetn)
      sleep_mode && !config_mode && $past(sleep_mode) && $past(config_mode) == 1'b0
      && cfg0.low_side && cfg0.polarity && $stable(state.driver_config) |-> !serial_tx_pin0)
      else $error("sleep pin0 not recessive");
   AST_BIPHASE_ONE: assert property (@(posedge core_clk) disable iff (!resetn)
      !config_mode && !sleep_mode && out_mode == CBS_MODE_BIPHASE && state.tx_bit
      |=> !serial_tx_pin0_oe || $past(config_mode))
      else $error("bi-phase recessive bit not floating");
   // a dominant bi-phase bit must never drive both pins at once,
   // otherwise the line would carry a dc component
   AST_BIPHASE_SPLIT: assert property (@(posedge core_clk) disable iff (!resetn)
      !config_mode && !sleep_mode && out_mode == CBS_MODE_BIPHASE && !state.tx_bit
      |=> !(serial_tx_pin0_oe && serial_tx_pin1_oe))
      else $error("bi-phase dominant bit on both pins");
   // push-pull pin 1 in clock mode shows the pulse right after bit start
   AST_CLK_PULSE: assert property (@(posedge core_clk) disable iff (!resetn)
      bit_start && out_mode == CBS_MODE_CLOCK && !config_mode && !sleep_mode
      && cfg1.high_side && cfg1.low_side && !cfg1.polarity
      |=> serial_tx_pin1 && serial_tx_pin1_oe)
      else $error("clock pulse missing at bit start");
   // test mode routes the synchronised comparator onto pin 1
   AST_TEST_ROUTE: assert property (@(posedge core_clk) disable iff (!resetn)
      !config_mode && !sleep_mode && out_mode == CBS_MODE_TEST
      && cfg1.high_side && !cfg1.low_side && !cfg1.polarity
      |=> serial_tx_pin1 == $past(rx_level))
      else $error("comparator not routed to pin1");
   // normal mode push-pull pin 0 follows the bit being sent
   AST_NORMAL_PIN0: assert property (@(posedge core_clk) disable iff (!resetn)
      !config_mode && !sleep_mode && out_mode == CBS_MODE_NORMAL
      && cfg0.high_side && cfg0.low_side && !cfg0.polarity
      |=> serial_tx_pin0 == $past(state.tx_bit) && serial_tx_pin0_oe)
      else $error("pin0 does not follow bit in normal mode");
   // the segment counters never run past their programmed lengths
   AST_SEG_BEFORE: assert property (@(posedge core_clk) disable iff (!resetn)
      state.seg == CBS_BEFORE |-> state.quanta <= seg_before)
      else $error("segment before sample overran");
   AST_SEG_AFTER: assert property (@(posedge core_clk) disable iff (!resetn)
      state.seg == CBS_AFTER |-> state.quanta <= {1'b0, seg_after})
      else $error("segment after sample overran");
   // quantum ticks are single-cycle enables, never back to back,
   // since the shortest quantum is two oscillator periods
   AST_QUANTUM_GAP: assert property (@(posedge core_clk) disable iff (!resetn)
      quantum_tick |=> !quantum_tick)
      else $error("quantum ticks back to back");
endmodule : cbs_bit_timing
`default_nettype wire

// ==== tb/cbs_bus_model.sv ====
// bus line model: resolves both transmit pins and other nodes into the comparator level
`timescale 1ns/1ps
`default_nettype none
module cbs_bus_model (
   // transmit pins of the device
   input wire logic pin0,
   input wire logic pin0_oe,
   input wire logic pin1,
   input wire logic pin1_oe,
   // another node pulling the line dominant
   input wire logic inject_dominant,
   // comparator output towards the device
   output logic rx_comp_pin
);
   ////////////////////////////////////////////////////////////////////////////////
   // wired line: a driven low or another node wins, else the termination holds recessive
   assign rx_comp_pin = !(inject_dominant | (pin0_oe & !pin0) | (pin1_oe & !pin1));
endmodule : cbs_bus_model
`default_nettype wire

// ==== tb/can_bit_segment_and_output_driver_test.sv ====
// testbench for the bit segment timing and output driver block
`timescale 1ns/1ps
`default_nettype none
`include "cbs_regs.svh"
module can_bit_segment_and_output_driver_test;
   logic core_clk, resetn, reg_wr, reg_rd, tx_data, rx_comp_pin, inject;
   logic [3:0] reg_addr;
   logic [7:0] reg_wr_data, reg_rd_data;
   logic rx_bit, rx_bit_valid, bit_start, p0, p0_oe, p1, p1_oe;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   cbs_bit_timing DUT (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
      .tx_data(tx_data), .rx_comp_pin(rx_comp_pin), .rx_bit(rx_bit),
      .rx_bit_valid(rx_bit_valid), .bit_start(bit_start), .serial_tx_pin0(p0),
      .serial_tx_pin0_oe(p0_oe), .serial_tx_pin1(p1), .serial_tx_pin1_oe(p1_oe));
   cbs_bus_model bus (.pin0(p0), .pin0_oe(p0_oe), .pin1(p1), .pin1_oe(p1_oe),
      .inject_dominant(inject), .rx_comp_pin(rx_comp_pin));
   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         $display("mismatch timeout expected finish seen hang");
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // shared tasks
   task close_out();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // expected {level, oe}: low side on when bit matches polarity, high side otherwise
   function automatic logic [1:0] drv(input logic [2:0] c, input logic b);
      logic hi, lo;
      hi = c[2] & (b != c[0]);
      lo = c[1] & (b == c[0]);
      return {hi, hi | lo};
   endfunction : drv
   task wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task rd(input logic [3:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 check("read data", reg_rd_data, exp);
      @(posedge core_clk);
   endtask : rd
   // config on, then prescaler, segments and drivers
   task setup(input logic [7:0] seg, input logic [7:0] drv_cfg, input logic [7:0] pre);
      wr(`CBS_OFF_MODE_CTRL, 8'h01);
      wr(`CBS_OFF_PRESCALE, pre);
      wr(`CBS_OFF_BIT_SEGMENT, seg);
      wr(`CBS_OFF_DRIVER, drv_cfg);
   endtask : setup
   // returns at the edge that ends a cycle with bit_start high
   task wait_bs();
      int n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (bit_start !== 1'b1 && n < 400);
      @(posedge core_clk);
   endtask : wait_bs
   task see_pins(input logic [1:0] e0, input logic [1:0] e1);
      @(negedge core_clk);
      check("pin0", {6'h0, p0, p0_oe}, {6'h0, e0});
      check("pin1", {6'h0, p1, p1_oe}, {6'h0, e1});
      @(posedge core_clk);
   endtask : see_pins
   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_regs();
      rd(`CBS_OFF_BIT_SEGMENT, 8'h00);
      wr(`CBS_OFF_BIT_SEGMENT, 8'ha5);
      wr(`CBS_OFF_DRIVER, 8'h3c);
      rd(`CBS_OFF_BIT_SEGMENT, 8'ha5);
      rd(`CBS_OFF_DRIVER, 8'h3c);
      wr(`CBS_OFF_MODE_CTRL, 8'h00);
      wr(`CBS_OFF_BIT_SEGMENT, 8'h11);
      rd(`CBS_OFF_BIT_SEGMENT, 8'h00);
      rd(4'hf, 8'h00);
      wr(`CBS_OFF_MODE_CTRL, 8'h01);
      rd(`CBS_OFF_BIT_SEGMENT, 8'ha5);
      $display("test registers done");
   endtask : t_regs
   task t_timing();
      int n;
      logic [7:0] segs [2] = '{8'h21, 8'h7f};
      logic [7:0] pres [2] = '{8'h00, 8'h01};
      int lens [2] = '{12, 100};
      for (int i = 0; i < 2; i++) begin
         setup(segs[i], 8'h02, pres[i]);
         wr(`CBS_OFF_MODE_CTRL, 8'h00);
         wait_bs();
         n = 0;
         do begin
            @(negedge core_clk);
            n++;
         end while (bit_start !== 1'b1 && n < 400);
         @(posedge core_clk);
         check("bit length", n[7:0], lens[i][7:0]);
      end
      $display("test timing done");
   endtask : t_timing
   task t_drivers();
      logic [2:0] c;
      for (int i = 0; i < 16; i++) begin
         c = i[3:1];
         setup(8'h21, {c, c, 2'b10}, 8'h00);
         see_pins(2'b00, 2'b00);
         tx_data <= i[0];
         wr(`CBS_OFF_MODE_CTRL, 8'h00);
         wait_bs();
         wait_bs();
         repeat (2) @(posedge core_clk);
         see_pins(drv(c, i[0]), drv(c, i[0]));
      end
      $display("test drivers done");
   endtask : t_drivers
   task t_sleep();
      setup(8'h21, 8'hda, 8'h00);
      tx_data <= 1'b0;
      wr(`CBS_OFF_MODE_CTRL, 8'h02);
      repeat (40) @(posedge core_clk);
      see_pins(drv(3'b110, 1'b1), drv(3'b110, 1'b1));
      wr(`CBS_OFF_MODE_CTRL, 8'h00);
      wait_bs();
      wait_bs();
      repeat (2) @(posedge core_clk);
      see_pins(drv(3'b110, 1'b0), drv(3'b110, 1'b0));
      $display("test sleep done");
   endtask : t_sleep
   task t_clock();
      int n, hi;
      setup(8'h21, 8'hdb, 8'h00);
      tx_data <= 1'b0;
      wr(`CBS_OFF_MODE_CTRL, 8'h00);
      wait_bs();
      wait_bs();
      n = 0;
      hi = 0;
      do begin
         @(negedge core_clk);
         n++;
         if (p1 === 1'b1 && p1_oe === 1'b1) hi++;
      end while (bit_start !== 1'b1 && n < 400);
      @(posedge core_clk);
      check("clock pulse", hi[7:0], 8'h02);
      see_pins(drv(3'b110, 1'b0), 2'b11);
      $display("test clock done");
   endtask : t_clock
   task t_biphase();
      logic tx_next [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
      logic [1:0] e0 [5] = '{2'b00, 2'b01, 2'b00, 2'b00, 2'b01};
      logic [1:0] e1 [5] = '{2'b00, 2'b00, 2'b00, 2'b01, 2'b00};
      setup(8'h21, 8'hd8, 8'h00);
      tx_data <= 1'b1;
      wr(`CBS_OFF_MODE_CTRL, 8'h00);
      for (int k = 0; k < 5; k++) begin
         wait_bs();
         repeat (3) @(posedge core_clk);
         tx_data <= tx_next[k];
         if (k > 0) see_pins(e0[k], e1[k]);
      end
      $display("test bi-phase done");
   endtask : t_biphase
   task t_test_mode();
      setup(8'h21, 8'h99, 8'h00);
      tx_data <= 1'b1;
      inject <= 1'b1;
      wr(`CBS_OFF_MODE_CTRL, 8'h00);
      repeat (30) @(posedge core_clk);
      see_pins(2'b11, 2'b00);
      inject <= 1'b0;
      repeat (30) @(posedge core_clk);
      see_pins(2'b11, 2'b11);
      $display("test comparator mode done");
   endtask : t_test_mode
   // sweep a one-quantum spike across a bit: only single sampling may catch it
   task t_sample();
      int hits, n, v;
      for (int triple_sample_select = 0; triple_sample_select < 2; triple_sample_select++) begin
         setup({triple_sample_select[0], 7'h21}, 8'h02, 8'h00);
         wr(`CBS_OFF_MODE_CTRL, 8'h00);
         hits = 0;
         for (int off = 0; off < 12; off++) begin
            wait_bs();
            repeat (off) @(posedge core_clk);
            inject <= 1'b1;
            repeat (2) @(posedge core_clk);
            inject <= 1'b0;
            n = 0;
            v = 0;
            do begin
               @(negedge core_clk);
               n++;
               if (rx_bit_valid === 1'b1) begin
                  v++;
                  if (rx_bit !== 1'b1) hits++;
               end
            end while (v < 2 && n < 60);
            @(posedge core_clk);
         end
         check("spike seen", {7'h0, hits != 0}, {7'h0, triple_sample_select == 0});
      end
      $display("test sampling done");
   endtask : t_sample
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      resetn = 1'b0;
      reg_addr = 4'h0;
      reg_wr_data = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      tx_data = 1'b1;
      inject = 1'b0;
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      t_regs();
      t_timing();
      t_drivers();
      t_sleep();
      t_clock();
      t_biphase();
      t_test_mode();
      t_sample();
      close_out();
   end
endmodule : can_bit_segment_and_output_driver_test
`default_nettype wire
